// ---- bmct_master.sv ----
`timescale 1ns/1ps
`default_nettype none

module bmct_master (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // microsequencer side
    input  wire logic       bus_start_state,
    input  wire logic [8:0] start_addr,
    input  wire logic       late_load,
    input  wire logic       long_logic_delay,
    input  wire logic       bus_end_state,
    // bus handshake
    output logic            msyn,
    input  wire logic       ssyn,
    // status
    output logic            cycle_active,
    output logic            skew_settled_flag,
    output logic            cycle_done
);

    // ============================================================
    // address decode
    // starts that change the data lines late need the extended strobe delay;
    // any other address keeps the normal strobe delay unless late_load is set
    function automatic logic is_ext_addr(input logic [8:0] a);
        if (a == bmct_pkg::EXT_ADDR_0) begin
            is_ext_addr = 1'b1;
        end else if (a == bmct_pkg::EXT_ADDR_1) begin
            is_ext_addr = 1'b1;
        end else if (a == bmct_pkg::EXT_ADDR_2) begin
            is_ext_addr = 1'b1;
        end else if (a == bmct_pkg::EXT_ADDR_3) begin
            is_ext_addr = 1'b1;
        end else if (a == bmct_pkg::EXT_ADDR_4) begin
            is_ext_addr = 1'b1;
        end else if (a == bmct_pkg::EXT_ADDR_5) begin
            is_ext_addr = 1'b1;
        end else if (a == bmct_pkg::EXT_ADDR_6) begin
            is_ext_addr = 1'b1;
        end else begin
            is_ext_addr = 1'b0;
        end
    endfunction

    // ============================================================
    // delay selection
    // cycles from the end of T2 until the skew-settled flag
    function automatic logic [bmct_pkg::CNT_W-1:0] settle_count(input logic lng);
        if (lng) begin
            settle_count = bmct_pkg::CNT_W'(bmct_pkg::DESKEW_LONG_CYC);
        end else begin
            settle_count = bmct_pkg::CNT_W'(bmct_pkg::DESKEW_SHORT_CYC);
        end
    endfunction

    // cycles from the end of T2 until the strobe, longer when the data lines moved late
    function automatic logic [bmct_pkg::CNT_W-1:0] strobe_count(input logic ext, input logic lng);
        if (!ext) begin
            strobe_count = bmct_pkg::CNT_W'(bmct_pkg::STROBE_CYC);
        end else if (lng) begin
            strobe_count = bmct_pkg::CNT_W'(bmct_pkg::STROBE_CYC + bmct_pkg::EXT_LONG_CYC);
        end else begin
            strobe_count = bmct_pkg::CNT_W'(bmct_pkg::STROBE_CYC + bmct_pkg::EXT_SHORT_CYC);
        end
    endfunction

    // ============================================================
    // closing time states
    // next time state of the T3, T4, T5 run
    function automatic bmct_pkg::bmct_state_t tail_next(input bmct_pkg::bmct_state_t s);
        case (s)
            bmct_pkg::BMCT_TS_T3: begin
                tail_next = bmct_pkg::BMCT_TS_T4;
            end
            default: begin
                tail_next = bmct_pkg::BMCT_TS_T5;
            end
        endcase
    endfunction

    // ============================================================
    // state
    // all state of the block sits in one register
    typedef struct packed {
        // sequencing
        bmct_pkg::bmct_state_t         st;
        logic [bmct_pkg::CNT_W-1:0]    cnt;
        // delays chosen when the start is taken
        logic [bmct_pkg::CNT_W-1:0]    settle_cyc;
        logic [bmct_pkg::CNT_W-1:0]    strobe_cyc;
        // flags shown on the outputs
        logic                          settled;
        logic                          strobe;
        logic                          active;
        logic                          done;
    } bmct_regs_t;

    bmct_regs_t r_q;
    bmct_regs_t r_d;

    always_comb begin
        // every field holds unless changed below; done is a one-cycle pulse
        r_d      = r_q;
        r_d.done = 1'b0;
        case (r_q.st)
            // ============================================================
            // idle: a start is only taken here, so one arriving mid-cycle is ignored
            bmct_pkg::BMCT_TS_IDLE: begin
                if (bus_start_state) begin
                    r_d.st      = bmct_pkg::BMCT_TS_T1;
                    r_d.cnt     = bmct_pkg::CNT_W'(bmct_pkg::START_CYC - 1);
                    r_d.active  = 1'b1;
                    r_d.settled = 1'b0;
                    r_d.settle_cyc = settle_count(long_logic_delay);
                    r_d.strobe_cyc = strobe_count(is_ext_addr(start_addr) || late_load, long_logic_delay);
                end
            end

            // ============================================================
            // T1 and T2 share one 60 ns count
            // a bus end here drops the start without any memory cycle
            bmct_pkg::BMCT_TS_T1, bmct_pkg::BMCT_TS_T2: begin
                if (bus_end_state) begin
                    r_d.st     = bmct_pkg::BMCT_TS_IDLE;
                    r_d.active = 1'b0;
                end else if (r_q.cnt == '0) begin
                    r_d.st  = bmct_pkg::BMCT_TS_WAIT;
                    r_d.cnt = '0;
                end else begin
                    r_d.cnt = r_q.cnt - 1'b1;
                    if (r_q.cnt <= bmct_pkg::CNT_W'(bmct_pkg::TSTATE_CYC)) begin
                        r_d.st = bmct_pkg::BMCT_TS_T2;
                    end
                end
            end

            // ============================================================
            // pause: strobe and interlocked handshake
            // settle and strobe delays are both counted from the end of T2,
            // so one counter serves both
            bmct_pkg::BMCT_TS_WAIT: begin
                // strobe generation enabled from end of T2
                if (!r_q.strobe) begin
                    r_d.cnt = r_q.cnt + 1'b1;
                    if (r_q.cnt + 1'b1 >= r_q.settle_cyc) begin
                        r_d.settled = 1'b1;
                    end
                    if (r_q.cnt + 1'b1 >= r_q.strobe_cyc) begin
                        r_d.strobe = 1'b1;
                    end
                end else if (ssyn) begin
                    // held here until the slave answers, however late
                    r_d.strobe = 1'b0;
                    r_d.st     = bmct_pkg::BMCT_TS_T3;
                    r_d.cnt    = bmct_pkg::CNT_W'(bmct_pkg::TAIL_CYC - 1);
                end
            end

            // ============================================================
            // closing T3 to T5; the next start may be taken while done shows
            bmct_pkg::BMCT_TS_T3, bmct_pkg::BMCT_TS_T4, bmct_pkg::BMCT_TS_T5: begin
                // 80 ns tail (four cycles), then ready for the next start within 60 ns
                if (r_q.cnt == '0) begin
                    r_d.st      = bmct_pkg::BMCT_TS_IDLE;
                    r_d.active  = 1'b0;
                    r_d.settled = 1'b0;
                    r_d.done    = 1'b1;
                end else begin
                    r_d.cnt = r_q.cnt - 1'b1;
                    r_d.st  = tail_next(r_q.st);
                end
            end
            default: begin
                r_d.st = bmct_pkg::BMCT_TS_IDLE;
            end
        endcase
    end

    // ============================================================
    // registers
    // synchronous reset clears every field, outputs included
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ============================================================
    // outputs
    // every output is a bit of the state register
    assign msyn              = r_q.strobe;
    assign cycle_active      = r_q.active;
    assign skew_settled_flag = r_q.settled;
    assign cycle_done        = r_q.done;

endmodule // bmct_master

`default_nettype wire

// ---- bmct_master_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// checker
module bmct_master_assertions (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    // microsequencer side
    input wire logic       bus_start_state,
    input wire logic [8:0] start_addr,
    input wire logic       late_load,
    input wire logic       long_logic_delay,
    input wire logic       bus_end_state,
    // handshake and status
    input wire logic       msyn,
    input wire logic       ssyn,
    input wire logic       cycle_active,
    input wire logic       skew_settled_flag,
    input wire logic       cycle_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    chk_strobe_held: assert property (msyn && !ssyn |=> msyn) else $error("strobe dropped");
    chk_strobe_release: assert property (msyn && ssyn |=> !msyn) else $error("strobe kept");
    chk_tail_length: assert property (msyn && ssyn |=> !cycle_done[*4] ##1 cycle_done) else $error("tail");
    chk_start_taken: assert property (!cycle_active && bus_start_state |=> cycle_active) else $error("start");
    chk_done_ends: assert property (cycle_done |-> !cycle_active ##1 !cycle_done) else $error("done");
    chk_strobe_late: assert property ($rose(cycle_active) |-> !msyn[*8]) else $error("early strobe");
    chk_settle_first: assert property ($rose(msyn) |-> skew_settled_flag) else $error("unsettled");
    chk_idle_quiet: assert property (!cycle_active |-> !msyn) else $error("idle strobe");
    cover property (msyn && ssyn);
    cover property (cycle_done);
    cover property ($rose(skew_settled_flag));
endmodule // bmct_master_assertions
bind bmct_master bmct_master_assertions i_bmct_master_assertions (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .bus_start_state(bus_start_state), .start_addr(start_addr), .late_load(late_load),
    .long_logic_delay(long_logic_delay), .bus_end_state(bus_end_state), .msyn(msyn), .ssyn(ssyn),
    .cycle_active(cycle_active), .skew_settled_flag(skew_settled_flag), .cycle_done(cycle_done));
`default_nettype wire

// ---- bmct_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// core memory on the far side of the handshake
module bmct_mem_model (
    input wire logic       ref_clk,
    input wire logic       msyn,
    input wire logic [5:0] acc_cyc,
    input wire logic [5:0] busy_cyc,
    output logic           ssyn
);
    int cnt = 0;
    int busy = 0;
    initial ssyn = 1'h0;
    always @(negedge ref_clk) begin
        if (ssyn) begin
            if (!msyn) begin
                ssyn <= 1'h0;
                busy <= busy_cyc;
                cnt <= 0;
            end
        end else if (busy > 0) begin
            busy <= busy - 1;
        end else if (msyn) begin
            cnt <= cnt + 1;
            ssyn <= (cnt + 1 >= acc_cyc);
        end
    end
endmodule // bmct_mem_model
`default_nettype wire

// ---- bmct_pkg.sv ----
package bmct_pkg;

    // ============================================================
    // time states
    typedef enum logic [2:0] {
        BMCT_TS_IDLE = 3'b000,
        BMCT_TS_T1   = 3'b001,
        BMCT_TS_T2   = 3'b010,
        BMCT_TS_WAIT = 3'b011,
        BMCT_TS_T3   = 3'b100,
        BMCT_TS_T4   = 3'b101,
        BMCT_TS_T5   = 3'b110
    } bmct_state_t;

    // ============================================================
    // timing in ns and derived cycle counts at 50 MHz
    localparam int CLK_PERIOD_NS       = 20;
    localparam int TSTATE_NS           = 30;
    localparam int START_NS            = 60;
    localparam int STROBE_ISSUE_NS     = 235;
    localparam int DESKEW_SHORT_NS     = 30;
    localparam int DESKEW_LONG_NS      = 60;
    localparam int EXT_ADD_SHORT_NS    = 90;
    localparam int EXT_ADD_LONG_NS     = 120;
    localparam int RESTART_NS          = 140;
    localparam int TAIL_NS             = 90;

    // least times round up
    localparam int START_CYC        = (START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DESKEW_SHORT_CYC = (DESKEW_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DESKEW_LONG_CYC  = (DESKEW_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC       = (STROBE_ISSUE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXT_SHORT_CYC    = (EXT_ADD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXT_LONG_CYC     = (EXT_ADD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest times round down
    localparam int RESTART_CYC      = RESTART_NS / CLK_PERIOD_NS;
    localparam int TAIL_CYC         = TAIL_NS / CLK_PERIOD_NS;
    localparam int TSTATE_CYC       = TSTATE_NS / CLK_PERIOD_NS;

    localparam int CNT_W = 5;

    // ============================================================
    // control-store addresses of starts needing the extended delay
    localparam logic [8:0] EXT_ADDR_0 = 9'o001;
    localparam logic [8:0] EXT_ADDR_1 = 9'o002;
    localparam logic [8:0] EXT_ADDR_2 = 9'o311;
    localparam logic [8:0] EXT_ADDR_3 = 9'o122;
    localparam logic [8:0] EXT_ADDR_4 = 9'o123;
    localparam logic [8:0] EXT_ADDR_5 = 9'o031;
    localparam logic [8:0] EXT_ADDR_6 = 9'o245;

endpackage

// ---- test_bmct_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench
module test_bmct_master;
    logic ref_clk = 0, sys_rst = 1, bus_start_state = 0, late_load = 0, long_logic_delay = 0, bus_end_state = 0;
    logic [8:0] start_addr = 9'h000;
    logic [5:0] acc_cyc = 6'h07, busy_cyc = 6'h00;
    logic msyn, ssyn, cycle_active, skew_settled_flag, cycle_done;
    int num_errors = 0, check_count = 0, n;
    logic [8:0] ext_tab [7] = '{9'h001, 9'h002, 9'h0C9, 9'h052, 9'h053, 9'h019, 9'h0A5};
    bmct_master i_bmct_master (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_start_state(bus_start_state),
        .start_addr(start_addr), .late_load(late_load), .long_logic_delay(long_logic_delay),
        .bus_end_state(bus_end_state), .msyn(msyn), .ssyn(ssyn), .cycle_active(cycle_active),
        .skew_settled_flag(skew_settled_flag), .cycle_done(cycle_done));
    bmct_mem_model i_bmct_mem_model (.ref_clk(ref_clk), .msyn(msyn), .acc_cyc(acc_cyc), .busy_cyc(busy_cyc),
        .ssyn(ssyn));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check(string what, int exp, int got);
        check_count++;
        if (exp != got) begin
            num_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // counts falling edges after the start edge until the strobe shows
    task automatic wait_msyn(int lim);
        n = 0;
        while (msyn !== 1'h1 && n < lim) begin
            @(negedge ref_clk);
            n++;
            bus_start_state = 0;
        end
    endtask
    task automatic run_cycle(logic [8:0] a, logic late, logic lng);
        int t = 0;
        int ext = late;
        foreach (ext_tab[i]) if (ext_tab[i] == a) ext = 1;
        start_addr = a;
        late_load = late;
        long_logic_delay = lng;
        bus_start_state = 1;
        acc_cyc = 6'(7 + $urandom_range(13));
        busy_cyc = 6'($urandom_range(40));
        wait_msyn(60);
        check("strobe delay", 1 + bmct_pkg::START_CYC + bmct_pkg::STROBE_CYC
            + (ext == 0 ? 0 : lng ? bmct_pkg::EXT_LONG_CYC : bmct_pkg::EXT_SHORT_CYC), n);
        check("settled at strobe", 1, skew_settled_flag === 1'h1);
        while (cycle_done !== 1'h1 && t < 100) begin
            @(negedge ref_clk);
            t++;
        end
        check("cycle done", 1, t < 100);
        if (t >= 100) stop_test();
        check("active at done", 0, cycle_active !== 1'h0);
    endtask
    initial begin
        void'($urandom(96131));
        repeat (10) @(negedge ref_clk);
        sys_rst = 0;
        foreach (ext_tab[i]) run_cycle(ext_tab[i], 0, i[0]);
        run_cycle(9'h1FF, 1, 1);
        run_cycle(9'h000, 0, 1);
        repeat (12) run_cycle(9'($urandom), 1'($urandom), 1'($urandom));
        bus_start_state = 1;
        @(negedge ref_clk);
        bus_start_state = 0;
        bus_end_state = 1;
        @(negedge ref_clk);
        bus_end_state = 0;
        wait_msyn(30);
        check("cancelled strobe", 30, n);
        check("cancelled active", 0, cycle_active !== 1'h0);
        stop_test();
    end
endmodule // test_bmct_master
`default_nettype wire
